// ==== rtl/wps_regs.svh ====
// Purpose: Register offsets, field positions, reset values and timing counts
//          of the wake-up and power-state controller.
// Assumes: 32-bit register port, byte addresses, 250 MHz system clock.
// Notes:   Definitions only.
`ifndef WPS_REGS_SVH
`define WPS_REGS_SVH

// Register byte offsets
`define WPS_OFF_PWR_CTRL     8'h00
`define WPS_OFF_WAKE_MASK    8'h04
`define WPS_OFF_TMR_RELOAD   8'h08
`define WPS_OFF_LF_DUTY      8'h0c
`define WPS_OFF_STATUS       8'h10

// Fields of the power control register
`define WPS_PC_SOFT_RST      0
`define WPS_PC_TMR_RST_EN    1
`define WPS_PC_TMR_EN        2
`define WPS_PC_LF_WAKE_EN    4
`define WPS_PC_TSHDWN_EN     5
`define WPS_PC_IDLE          6
`define WPS_PC_PDWN          7

// Fields of the wake mask register (1 = source enabled)
`define WPS_WM_TIMER         0
`define WPS_WM_LF_CARRIER    1
`define WPS_WM_LF_ID         2
`define WPS_WM_LF_SYNC       3
`define WPS_WM_GPIO_LSB      4
`define WPS_WM_OVER_TEMP_DETECTOR          10
`define WPS_WM_WIDTH         11

// Fields of the LF duty register
`define WPS_LD_ON_LSB        0
`define WPS_LD_OFF_LSB       8
`define WPS_LD_CONT          16

// Reset values
`define WPS_RST_PWR_CTRL     8'h04
`define WPS_RST_WAKE_MASK    11'h7ff
`define WPS_RST_TMR_RELOAD   16'hffff
`define WPS_RST_LF_DUTY      17'h00801

// Timing: wake timer and LF on-off timer tick at 1 ms
`define WPS_CLK_MHZ          250
`define WPS_TICK_US          1000

`endif

// ==== rtl/wps_pkg.sv ====
// Purpose: Types of the wake-up and power-state controller.
// Assumes: Constants live in wps_regs.svh.
// Notes:   State codes are one-hot.
package wps_pkg;

    typedef enum logic [4:0] {
        WPS_ST_INIT  = 5'b00001,
        WPS_ST_RUN   = 5'b00010,
        WPS_ST_IDLE  = 5'b00100,
        WPS_ST_PDOWN = 5'b01000,
        WPS_ST_TSHDN = 5'b10000
    } wps_state_t;

    typedef enum logic [1:0] {
        WPS_MODE_RESERVED = 2'b00,
        WPS_MODE_DEBUG    = 2'b01,
        WPS_MODE_PROGRAM  = 2'b10,
        WPS_MODE_NORMAL   = 2'b11
    } wps_mode_t;

    typedef struct packed {
        logic cpu_clk_en;
        logic core_supply_en;
        logic core_active;
        logic regulator_en;
        logic hf_osc_en;
    } wps_pwr_t;

endpackage : wps_pkg

// ==== rtl/wps_ctrl.sv ====
// Purpose: Always-on wake-up and power-state controller: strap mode latch,
//          device state sequencing, power gating, wake and reset collection.
// Assumes: i_rst_n is the combined power-on reset; pins are asynchronous.
// Notes:   Register port answers one cycle after a read strobe.
`timescale 1ns/1ns
`default_nettype none
`include "wps_regs.svh"

module wps_ctrl
    import wps_pkg::*;
#(
    parameter int TICK_CYCLES = `WPS_TICK_US * `WPS_CLK_MHZ
) (
    // Clock and power-on reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_n,
    // Pins
    input  wire logic        i_strap_pin_low,
    input  wire logic        i_strap_pin_high,
    input  wire logic [5:0]  i_general_io_pins,
    input  wire logic        i_brown_out,
    // On-chip event sources
    input  wire logic        i_periph_irq,
    input  wire logic        i_lf_carrier,
    input  wire logic        i_lf_id_match,
    input  wire logic        i_lf_sync,
    input  wire logic        i_over_temp_alarm,
    input  wire logic        i_over_temp_good,
    input  wire logic        i_boot_done,
    // Register port
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    // Power and control outputs
    output wps_pwr_t         o_pwr,
    output logic             o_core_rst,
    output logic             o_boot_req,
    output logic             o_lf_rx_on,
    output logic             o_over_temp_detector_en,
    output wps_mode_t        o_mode,
    output wps_state_t       o_state
);

    // Power-on reset synchroniser
    logic rst_meta_reg;
    logic rst_n_reg;

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    // Pin synchronisers without reset, so straps are already settled when the mode is taken
    logic [8:0] pin_meta_reg;
    logic [8:0] pin_sync_reg;

    always_ff @(posedge i_sys_clk) begin
        pin_meta_reg <= {i_brown_out, i_strap_pin_high, i_strap_pin_low, i_general_io_pins};
        pin_sync_reg <= pin_meta_reg;
    end

    logic       brown_out;
    logic [1:0] strap;
    logic [5:0] gpio;
    assign brown_out = pin_sync_reg[8];
    assign strap     = pin_sync_reg[7:6];
    assign gpio      = pin_sync_reg[5:0];

    // Brown-out clears the settings, timers, wake cause, mode latch and state like power-on, but synchronously
    logic cold_rst;
    assign cold_rst = brown_out;

    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
        addr_is = (a == off);
    endfunction : addr_is

    // Operating mode latch; cleared only by power-on or brown-out
    logic      mode_taken_reg;
    wps_mode_t mode_reg;

    always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            mode_taken_reg <= 1'b0;
            mode_reg       <= WPS_MODE_RESERVED;
        end else if (cold_rst) begin
            mode_taken_reg <= 1'b0;
        end else if (!mode_taken_reg) begin
            mode_taken_reg <= 1'b1;
            mode_reg       <= wps_mode_t'(strap);
        end
    end

    // Always-on wake masks survive powerdown and warm resets
    logic [`WPS_WM_WIDTH-1:0] wake_mask_reg;
    logic                     wr_ok;
    wps_state_t               state_reg;
    wps_state_t               state_next;

    // Software writes take effect only while code runs
    assign wr_ok = i_wr && (state_reg == WPS_ST_RUN);

    always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            wake_mask_reg <= `WPS_RST_WAKE_MASK;
        end else if (cold_rst) begin
            wake_mask_reg <= `WPS_RST_WAKE_MASK;
        end else if (wr_ok && addr_is(i_addr, `WPS_OFF_WAKE_MASK)) begin
            wake_mask_reg <= i_wdata[`WPS_WM_WIDTH-1:0];
        end
    end

    // Warm reset: software request or enabled timer underflow
    logic [7:0] pwr_ctrl_reg;
    logic       tmr_uflow;
    logic       soft_rst;
    logic       warm_rst;
    logic       in_init_reg;

    assign soft_rst = wr_ok && addr_is(i_addr, `WPS_OFF_PWR_CTRL) && i_wdata[`WPS_PC_SOFT_RST];
    assign warm_rst = soft_rst || (tmr_uflow && pwr_ctrl_reg[`WPS_PC_TMR_RST_EN]);

    // Power control: cleared to wake values on every entry to init
    always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            pwr_ctrl_reg <= `WPS_RST_PWR_CTRL;
        end else if (cold_rst || state_reg == WPS_ST_INIT) begin
            pwr_ctrl_reg <= `WPS_RST_PWR_CTRL;
        end else if (wr_ok && addr_is(i_addr, `WPS_OFF_PWR_CTRL)) begin
            pwr_ctrl_reg <= i_wdata[7:0];
            pwr_ctrl_reg[`WPS_PC_SOFT_RST] <= 1'b0;
        end else if (state_reg != WPS_ST_RUN) begin
            // Request bits are consumed once the state is left
            pwr_ctrl_reg[`WPS_PC_PDWN] <= 1'b0;
            pwr_ctrl_reg[`WPS_PC_IDLE] <= 1'b0;
        end
    end

    // Timer reload and LF duty settings
    logic [15:0] tmr_reload_reg;
    logic [16:0] lf_duty_reg;

    always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            tmr_reload_reg <= `WPS_RST_TMR_RELOAD;
            lf_duty_reg    <= `WPS_RST_LF_DUTY;
        end else if (cold_rst) begin
            tmr_reload_reg <= `WPS_RST_TMR_RELOAD;
            lf_duty_reg    <= `WPS_RST_LF_DUTY;
        end else begin
            if (wr_ok && addr_is(i_addr, `WPS_OFF_TMR_RELOAD)) begin
                tmr_reload_reg <= i_wdata[15:0];
            end
            if (wr_ok && addr_is(i_addr, `WPS_OFF_LF_DUTY)) begin
                lf_duty_reg <= i_wdata[16:0];
            end
        end
    end

    // Millisecond tick shared by the wake timer and LF on-off timer
    logic [31:0] tick_cnt_reg;
    logic        tick;
    assign tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));

    always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            tick_cnt_reg <= 32'h0;
        end else if (cold_rst || tick) begin
            tick_cnt_reg <= 32'h0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h1;
        end
    end

    // Periodic wake timer counts down and reloads after underflow
    logic [15:0] tmr_cnt_reg;
    assign tmr_uflow = tick && pwr_ctrl_reg[`WPS_PC_TMR_EN] && (tmr_cnt_reg == 16'h0);

    always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            tmr_cnt_reg <= `WPS_RST_TMR_RELOAD;
        end else if (cold_rst) begin
            tmr_cnt_reg <= `WPS_RST_TMR_RELOAD;
        end else if (wr_ok && addr_is(i_addr, `WPS_OFF_TMR_RELOAD)) begin
            tmr_cnt_reg <= i_wdata[15:0];
        end else if (tmr_uflow) begin
            tmr_cnt_reg <= tmr_reload_reg;
        end else if (tick && pwr_ctrl_reg[`WPS_PC_TMR_EN]) begin
            tmr_cnt_reg <= tmr_cnt_reg - 16'h1;
        end
    end

    // LF on-off timer; on and off lengths in ticks, off code 0 keeps it on
    logic       lf_on_reg;
    logic [7:0] lf_cnt_reg;
    logic       lf_cont;
    assign lf_cont = lf_duty_reg[`WPS_LD_CONT] || (lf_duty_reg[`WPS_LD_OFF_LSB +: 8] == 8'h0);

    always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            lf_on_reg  <= 1'b0;
            lf_cnt_reg <= 8'h0;
        end else if (cold_rst || !pwr_ctrl_reg[`WPS_PC_LF_WAKE_EN]) begin
            lf_on_reg  <= 1'b0;
            lf_cnt_reg <= 8'h0;
        end else if (lf_cont) begin
            lf_on_reg  <= 1'b1;
            lf_cnt_reg <= 8'h0;
        end else if (tick) begin
            if (lf_cnt_reg == 8'h0) begin
                lf_on_reg  <= !lf_on_reg;
                lf_cnt_reg <= lf_on_reg ? lf_duty_reg[`WPS_LD_OFF_LSB +: 8] - 8'h1
                                        : lf_duty_reg[`WPS_LD_ON_LSB +: 8] - 8'h1;
            end else begin
                lf_cnt_reg <= lf_cnt_reg - 8'h1;
            end
        end
    end

    // Wake sources, each gated by its mask
    logic [`WPS_WM_WIDTH-1:0] wake_src;
    logic                     wake_any;
    assign wake_src = {i_over_temp_good && state_reg == WPS_ST_TSHDN,
                       ~gpio,
                       i_lf_sync && lf_on_reg,
                       i_lf_id_match && lf_on_reg,
                       i_lf_carrier && lf_on_reg,
                       tmr_uflow};
    assign wake_any = |(wake_src[`WPS_WM_OVER_TEMP_DETECTOR-1:0] & wake_mask_reg[`WPS_WM_OVER_TEMP_DETECTOR-1:0]);

    // Shutdown release: temperature good first, then timer underflow
    logic temp_ok_seen_reg;

    always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            temp_ok_seen_reg <= 1'b0;
        end else if (state_reg != WPS_ST_TSHDN) begin
            temp_ok_seen_reg <= 1'b0;
        end else if (wake_src[`WPS_WM_OVER_TEMP_DETECTOR] && wake_mask_reg[`WPS_WM_OVER_TEMP_DETECTOR]) begin
            temp_ok_seen_reg <= 1'b1;
        end
    end

    // Device state sequencing
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            WPS_ST_INIT: begin
                if (i_boot_done && !in_init_reg) begin
                    state_next = WPS_ST_RUN;
                end
            end
            WPS_ST_RUN: begin
                if (pwr_ctrl_reg[`WPS_PC_PDWN]) begin
                    if (pwr_ctrl_reg[`WPS_PC_TSHDWN_EN] && i_over_temp_alarm) begin
                        state_next = WPS_ST_TSHDN;
                    end else begin
                        state_next = WPS_ST_PDOWN;
                    end
                end else if (pwr_ctrl_reg[`WPS_PC_IDLE]) begin
                    state_next = WPS_ST_IDLE;
                end
            end
            WPS_ST_IDLE: begin
                if (i_periph_irq || wake_any) begin
                    state_next = WPS_ST_RUN;
                end
            end
            WPS_ST_PDOWN: begin
                if (wake_any) begin
                    state_next = WPS_ST_INIT;
                end
            end
            WPS_ST_TSHDN: begin
                if (temp_ok_seen_reg && tmr_uflow) begin
                    state_next = WPS_ST_INIT;
                end
            end
            default: begin
                state_next = WPS_ST_INIT;
            end
        endcase
        // Only normal mode sequences low-power states
        if (mode_reg != WPS_MODE_NORMAL && state_next != WPS_ST_INIT) begin
            state_next = state_reg == WPS_ST_INIT ? state_next : WPS_ST_RUN;
        end
        if (warm_rst && state_reg != WPS_ST_TSHDN) begin
            state_next = WPS_ST_INIT;
        end
        if (cold_rst || !mode_taken_reg) begin
            state_next = WPS_ST_INIT;
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg <= WPS_ST_INIT;
        end else if (cold_rst || !mode_taken_reg) begin
            state_reg <= WPS_ST_INIT;
        end else begin
            state_reg <= state_next;
        end
    end

    // Core reset pulse on the first cycle of every init entry
    always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            in_init_reg <= 1'b1;
            o_core_rst  <= 1'b1;
            o_boot_req  <= 1'b0;
        end else begin
            in_init_reg <= (state_next == WPS_ST_INIT) && (state_reg != WPS_ST_INIT || cold_rst);
            o_core_rst  <= (state_next == WPS_ST_INIT) && (state_reg != WPS_ST_INIT);
            o_boot_req  <= (state_next == WPS_ST_INIT);
        end
    end

    // Power gating per state; low-frequency oscillators stay outside this block
    always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            o_pwr <= '0;
        end else begin
            o_pwr.cpu_clk_en     <= (state_next == WPS_ST_RUN) || (state_next == WPS_ST_INIT);
            o_pwr.core_supply_en <= (state_next != WPS_ST_PDOWN) && (state_next != WPS_ST_TSHDN);
            o_pwr.core_active    <= (state_next == WPS_ST_RUN) || (state_next == WPS_ST_INIT);
            o_pwr.regulator_en   <= (state_next != WPS_ST_PDOWN) && (state_next != WPS_ST_TSHDN);
            o_pwr.hf_osc_en      <= (state_next == WPS_ST_RUN) || (state_next == WPS_ST_INIT);
        end
    end

    // Misc outputs straight from flops
    always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            o_lf_rx_on <= 1'b0;
            o_over_temp_detector_en  <= 1'b0;
            o_mode     <= WPS_MODE_RESERVED;
            o_state    <= WPS_ST_INIT;
        end else begin
            o_lf_rx_on <= lf_on_reg;
            o_over_temp_detector_en  <= pwr_ctrl_reg[`WPS_PC_TSHDWN_EN] || state_reg == WPS_ST_TSHDN;
            o_mode     <= mode_reg;
            o_state    <= state_next;
        end
    end

    // Wake cause capture for software
    logic [`WPS_WM_WIDTH-1:0] wake_cause_reg;

    always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            wake_cause_reg <= '0;
        end else if (cold_rst) begin
            wake_cause_reg <= '0;
        end else if ((state_reg == WPS_ST_PDOWN || state_reg == WPS_ST_TSHDN) && state_next == WPS_ST_INIT) begin
            wake_cause_reg <= wake_src & wake_mask_reg;
        end
    end

    // Read data stands for one cycle after the strobe
    always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            o_rdata <= 32'h0;
        end else if (!i_rd) begin
            o_rdata <= 32'h0;
        end else if (addr_is(i_addr, `WPS_OFF_PWR_CTRL)) begin
            o_rdata <= {24'h0, pwr_ctrl_reg};
        end else if (addr_is(i_addr, `WPS_OFF_WAKE_MASK)) begin
            o_rdata <= {21'h0, wake_mask_reg};
        end else if (addr_is(i_addr, `WPS_OFF_TMR_RELOAD)) begin
            o_rdata <= {16'h0, tmr_reload_reg};
        end else if (addr_is(i_addr, `WPS_OFF_LF_DUTY)) begin
            o_rdata <= {15'h0, lf_duty_reg};
        end else if (addr_is(i_addr, `WPS_OFF_STATUS)) begin
            o_rdata <= {12'h0, wake_cause_reg, 1'b0, i_over_temp_good, mode_reg, state_reg};
        end else begin
            o_rdata <= 32'h0;
        end
    end

endmodule : wps_ctrl
`default_nettype wire

// ==== test/wps_ctrl_assertions.sv ====
// Purpose: Port-level checks of the wake-up and power-state controller.
// Assumes: One clock domain; i_rst_n is the power-on reset.
// Notes:   Bound to wps_ctrl from the bench top file.
`timescale 1ns/1ns
`default_nettype none
module wps_ctrl_checker
    import wps_pkg::*;
(
    // Clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_n,
    // Observed outputs
    input  wire wps_pwr_t   o_pwr,
    input  wire logic       o_core_rst,
    input  wire logic       o_boot_req,
    input  wire wps_mode_t  o_mode,
    input  wire wps_state_t o_state
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    property p_onehot; $onehot(o_state); endproperty
    a_onehot: assert property (p_onehot) else $error("state not one-hot");
    property p_run_pwr; o_state == WPS_ST_RUN |-> o_pwr.cpu_clk_en && o_pwr.core_supply_en; endproperty
    a_run_pwr: assert property (p_run_pwr) else $error("run without clock or supply");
    property p_rst_init; $rose(o_core_rst) |-> o_state == WPS_ST_INIT; endproperty
    a_rst_init: assert property (p_rst_init) else $error("core reset outside init");
    property p_rst_pulse; $rose(o_core_rst) |=> !o_core_rst; endproperty
    a_rst_pulse: assert property (p_rst_pulse) else $error("core reset longer than one cycle");
    property p_idle_gate; o_state == WPS_ST_IDLE |-> !o_pwr.cpu_clk_en && o_pwr.core_supply_en; endproperty
    a_idle_gate: assert property (p_idle_gate) else $error("idle gating wrong");
    property p_sleep_unsup;
        o_state inside {WPS_ST_PDOWN, WPS_ST_TSHDN} |-> !o_pwr.core_supply_en && !o_pwr.cpu_clk_en && !o_pwr.regulator_en;
    endproperty
    a_sleep_unsup: assert property (p_sleep_unsup) else $error("core supplied while asleep");
    property p_sleep_exit;
        ($past(o_state) inside {WPS_ST_PDOWN, WPS_ST_TSHDN}) && o_state != $past(o_state) |-> o_state == WPS_ST_INIT;
    endproperty
    a_sleep_exit: assert property (p_sleep_exit) else $error("sleep left other than through init");
    property p_mode_hold; o_state == WPS_ST_RUN && $past(o_state) == WPS_ST_RUN |-> $stable(o_mode); endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed while running");
    property p_boot_off; o_state == WPS_ST_RUN |-> !o_boot_req; endproperty
    a_boot_off: assert property (p_boot_off) else $error("boot request while running");
endmodule : wps_ctrl_checker
`default_nettype wire

// ==== test/wps_env.sv ====
// Purpose: Board and boot firmware model: strap levels and boot completion.
// Assumes: Straps change only while the bench holds reset or tests a mode.
// Notes:   Boot takes a fixed six cycles once requested.
`timescale 1ns/1ns
`default_nettype none
module wps_env (
    // Clock and boot handshake
    input  wire logic       i_clk,
    input  wire logic       i_boot_req,
    input  wire logic [1:0] i_mode_sel,
    // Pins toward the controller
    output logic            o_strap_low,
    output logic            o_strap_high,
    output logic            o_boot_done
);
    logic [3:0] cnt_reg = 4'h0;

    // Board holds the chosen straps steady
    assign o_strap_low  = i_mode_sel[0];
    assign o_strap_high = i_mode_sel[1];

    // Firmware boot runs before handing over to the application
    always_ff @(posedge i_clk) begin
        if (!i_boot_req) begin
            cnt_reg <= 4'h0;
        end else if (cnt_reg != 4'h6) begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end
    assign o_boot_done = (cnt_reg == 4'h6);
endmodule : wps_env
`default_nettype wire

// ==== test/wps_ctrl_bench.sv ====
// Purpose: Self-checking bench of the wake-up and power-state controller.
// Assumes: Timer tick shortened to 8 cycles.
// Notes:   LF event inputs stay low; only the continuous-on LF duty setting is exercised.
`timescale 1ns/1ns
`default_nettype none
`include "wps_regs.svh"
module wps_ctrl_bench
    import wps_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, bo = 1'b0, irq = 1'b0, alarm = 1'b0, good = 1'b0;
    logic lfc = 1'b0, lfi = 1'b0, lfs = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
    logic [1:0] mode_sel = 2'b11;
    logic [5:0] gpio = 6'h3f;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic s_lo, s_hi, boot_done, core_rst, boot_req, lf_on, over_temp_detector_en;
    wps_pwr_t pwr;
    wps_mode_t mode;
    wps_state_t st;
    int n_fail = 0, tests_run = 0;

    initial forever #2 clk = ~clk;

    wps_env i_wps_env (.i_clk(clk), .i_boot_req(boot_req), .i_mode_sel(mode_sel),
        .o_strap_low(s_lo), .o_strap_high(s_hi), .o_boot_done(boot_done));
    wps_ctrl #(.TICK_CYCLES(8)) i_wps_ctrl (.i_sys_clk(clk), .i_rst_n(rst_n), .i_strap_pin_low(s_lo),
        .i_strap_pin_high(s_hi), .i_general_io_pins(gpio), .i_brown_out(bo), .i_periph_irq(irq),
        .i_lf_carrier(lfc), .i_lf_id_match(lfi), .i_lf_sync(lfs), .i_over_temp_alarm(alarm),
        .i_over_temp_good(good), .i_boot_done(boot_done), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s),
        .i_rd(rd_s), .o_rdata(rdata), .o_pwr(pwr), .o_core_rst(core_rst), .o_boot_req(boot_req),
        .o_lf_rx_on(lf_on), .o_over_temp_detector_en(over_temp_detector_en), .o_mode(mode), .o_state(st));

    task automatic wrap_up();
        $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wait_st(input wps_state_t s, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            #1;
            if (st === s) return;
        end
        n_fail++;
        $display("ERROR t=%0t state=%h exp=%h", $time, st, s);
        wrap_up();
    endtask : wait_st

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        v = rdata;
    endtask : rd

    task automatic por();
        rst_n <= 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
    endtask : por

    task automatic t_mode();
        for (int m = 0; m < 4; m++) begin
            mode_sel <= 2'(m);
            por();
            repeat (12) @(posedge clk);
            chk(32'(mode), 32'(m));
        end
        mode_sel <= 2'b11;
        por();
        wait_st(WPS_ST_RUN, 100);
        $display("t_mode done");
    endtask : t_mode

    task automatic t_regs();
        rd(`WPS_OFF_STATUS, d);
        chk(32'(d[4:0]), 32'h2);
        chk(32'(d[6:5]), 32'h3);
        rd(`WPS_OFF_PWR_CTRL, d);
        chk(d, 32'h4);
        rd(`WPS_OFF_WAKE_MASK, d);
        chk(d, 32'h7ff);
        rd(8'h20, d);
        chk(d, 32'h0);
        chk(32'(over_temp_detector_en), 32'h0);
        wr(`WPS_OFF_LF_DUTY, 32'h10000);
        wr(`WPS_OFF_PWR_CTRL, 32'h14);
        repeat (3) @(posedge clk);
        chk(32'(lf_on), 32'h1);
        wr(`WPS_OFF_PWR_CTRL, 32'h4);
        repeat (3) @(posedge clk);
        chk(32'(lf_on), 32'h0);
        $display("t_regs done");
    endtask : t_regs

    task automatic t_gpio();
        wr(`WPS_OFF_PWR_CTRL, 32'h80);
        wait_st(WPS_ST_PDOWN, 10);
        chk(32'(pwr.core_supply_en), 32'h0);
        repeat (20) @(posedge clk);
        chk(32'(st), 32'(WPS_ST_PDOWN));
        gpio <= 6'h37;
        wait_st(WPS_ST_INIT, 10);
        gpio <= 6'h3f;
        wait_st(WPS_ST_RUN, 30);
        rd(`WPS_OFF_PWR_CTRL, d);
        chk(d, 32'h4);
        $display("t_gpio done");
    endtask : t_gpio

    task automatic t_mask();
        wr(`WPS_OFF_TMR_RELOAD, 32'ha);
        wr(`WPS_OFF_WAKE_MASK, 32'h1);
        wr(`WPS_OFF_PWR_CTRL, 32'h84);
        wait_st(WPS_ST_PDOWN, 10);
        gpio <= 6'h00;
        repeat (20) @(posedge clk);
        chk(32'(st), 32'(WPS_ST_PDOWN));
        wait_st(WPS_ST_INIT, 200);
        gpio <= 6'h3f;
        wait_st(WPS_ST_RUN, 30);
        rd(`WPS_OFF_WAKE_MASK, d);
        chk(d, 32'h1);
        rd(`WPS_OFF_STATUS, d);
        chk(32'(d[19:9]), 32'h1);
        wr(`WPS_OFF_TMR_RELOAD, 32'hffff);
        wr(`WPS_OFF_WAKE_MASK, 32'h7ff);
        $display("t_mask done");
    endtask : t_mask

    task automatic t_idle();
        wr(`WPS_OFF_PWR_CTRL, 32'h40);
        wait_st(WPS_ST_IDLE, 10);
        chk(32'(pwr.cpu_clk_en), 32'h0);
        wr(`WPS_OFF_PWR_CTRL, 32'h80);
        repeat (4) @(posedge clk);
        chk(32'(st), 32'(WPS_ST_IDLE));
        irq <= 1'b1;
        wait_st(WPS_ST_RUN, 20);
        irq <= 1'b0;
        $display("t_idle done");
    endtask : t_idle

    task automatic t_soft();
        mode_sel <= 2'b01;
        wr(`WPS_OFF_PWR_CTRL, 32'h1);
        wait_st(WPS_ST_INIT, 10);
        repeat (8) @(posedge clk);
        chk(32'(mode), 32'h3);
        wait_st(WPS_ST_RUN, 30);
        wr(`WPS_OFF_TMR_RELOAD, 32'h2);
        wr(`WPS_OFF_PWR_CTRL, 32'h6);
        wait_st(WPS_ST_INIT, 60);
        chk(32'(mode), 32'h3);
        mode_sel <= 2'b11;
        wait_st(WPS_ST_RUN, 30);
        $display("t_soft done");
    endtask : t_soft

    task automatic t_shut();
        wr(`WPS_OFF_TMR_RELOAD, 32'h2);
        alarm <= 1'b1;
        wr(`WPS_OFF_PWR_CTRL, 32'ha4);
        wait_st(WPS_ST_TSHDN, 10);
        chk(32'(pwr.core_supply_en), 32'h0);
        chk(32'(over_temp_detector_en), 32'h1);
        repeat (60) @(posedge clk);
        chk(32'(st), 32'(WPS_ST_TSHDN));
        good <= 1'b1;
        alarm <= 1'b0;
        wait_st(WPS_ST_INIT, 200);
        good <= 1'b0;
        wait_st(WPS_ST_RUN, 30);
        $display("t_shut done");
    endtask : t_shut

    task automatic t_brown();
        mode_sel <= 2'b01;
        bo <= 1'b1;
        repeat (4) @(posedge clk);
        bo <= 1'b0;
        repeat (16) @(posedge clk);
        chk(32'(mode), 32'h1);
        rd(`WPS_OFF_TMR_RELOAD, d);
        chk(d, 32'hffff);
        $display("t_brown done");
    endtask : t_brown

    initial begin
        por();
        wait_st(WPS_ST_RUN, 100);
        t_mode();
        t_regs();
        t_gpio();
        t_mask();
        t_idle();
        t_soft();
        t_shut();
        t_brown();
        wrap_up();
    end
endmodule : wps_ctrl_bench

bind wps_ctrl wps_ctrl_checker i_wps_ctrl_checker (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .o_pwr(o_pwr),
    .o_core_rst(o_core_rst), .o_boot_req(o_boot_req), .o_mode(o_mode), .o_state(o_state));
`default_nettype wire
